/* dcto_checker.sv */
`timescale 1ns/10ps
module dcto_checker #(
    parameter int unsigned FILTER_CYC = dcto_pkg::FILTER_CYC
) (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       safety_request_a,
    input wire logic       safety_request_b,
    input wire logic [3:0] controlword,
    input wire logic       controlword_strobe,
    input wire logic       hardwired_torque_off,
    input wire logic       power_stage_idle,
    input wire logic       servo_ready,
    input wire logic       operation_enabled,
    input wire logic       failure_monitor_output
);
    // ------------------------------------------------------------
    // both-off duration counter
    // ------------------------------------------------------------
    logic [15:0] both_off_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            both_off_q <= 16'h0000;
        end else if (safety_request_a || safety_request_b) begin
            both_off_q <= 16'h0000;
        end else if (both_off_q != 16'hFFFF) begin
            both_off_q <= both_off_q + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    fmo_off_a: assert property ((safety_request_a || safety_request_b) [*6] |-> !failure_monitor_output)
        else $error("monitor output on while a channel is on");
    shutoff_time_a: assert property (both_off_q >= FILTER_CYC + 6 |-> hardwired_torque_off && !operation_enabled && failure_monitor_output)
        else $error("power not cut after both channels off");
    glitch_hold_a: assert property ($fell(safety_request_a) && safety_request_b && operation_enabled |=> operation_enabled [*8])
        else $error("short off pulse stopped the motor");
    torque_off_excl_a: assert property (hardwired_torque_off |-> !power_stage_idle && !operation_enabled && !servo_ready)
        else $error("torque-off state mixed with other states");
    ready_needs_idle_a: assert property (servo_ready |-> power_stage_idle)
        else $error("servo ready outside idle");
    enable_runs_a: assert property (controlword_strobe && controlword == dcto_pkg::CW_ENABLE_OP && power_stage_idle
        && safety_request_a && safety_request_b |=> operation_enabled)
        else $error("enable from idle not accepted");
    shutdown_stops_a: assert property (controlword_strobe && controlword == dcto_pkg::CW_SHUTDOWN |=> !operation_enabled)
        else $error("shutdown left motor running");
    enable_after_idle_a: assert property (controlword_strobe && controlword == dcto_pkg::CW_ENABLE_OP |-> $past(power_stage_idle))
        else $error("enable sent before idle");

    cover property ($rose(operation_enabled));
    cover property ($rose(failure_monitor_output));
    cover property ($fell(safety_request_a) && safety_request_b && operation_enabled);
endmodule

/* dcto_drive.sv */
`timescale 1ns/10ps
module dcto_drive #(
    parameter int unsigned FILTER_CYC = dcto_pkg::FILTER_CYC,
    parameter int unsigned ALARM_CYC  = dcto_pkg::ALARM_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    dcto_if.drive                     link,
    input  wire logic                 main_power_on,
    input  wire logic                 utility_mode,
    input  wire dcto_pkg::dcto_util_e utility_id,
    input  wire logic                 alarm_clear,
    output logic                      gate_drive_a,
    output logic                      gate_drive_b,
    output logic                      input_timing_alarm
);

    localparam int FW = $clog2(FILTER_CYC + 1);
    localparam int AW = $clog2(ALARM_CYC + 1);

    // ------------------------------------------------------------
    // synchronise and filter each channel
    // ------------------------------------------------------------
    logic [1:0] raw;
    logic [1:0] filt;

    assign raw = {link.safety_request_b, link.safety_request_a};

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic          sync1_q;
        logic          sync2_q;
        logic          filt_q;
        logic [FW-1:0] off_cnt_q;

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                sync1_q <= 1'b0;
                sync2_q <= 1'b0;
            end else begin
                sync1_q <= raw[ch];
                sync2_q <= sync1_q;
            end
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                off_cnt_q <= '0;
                filt_q    <= 1'b0;
            end else if (sync2_q) begin
                off_cnt_q <= '0;
                filt_q    <= 1'b1;
            end else if (off_cnt_q == FW'(FILTER_CYC)) begin
                filt_q    <= 1'b0;
            end else begin
                off_cnt_q <= off_cnt_q + FW'(1);
            end
        end

        assign filt[ch] = filt_q;
    end

    logic both_on;
    assign both_on = filt[0] & filt[1];

    // ------------------------------------------------------------
    // single channel timing supervision
    // ------------------------------------------------------------
    logic [AW-1:0] mis_cnt_q;
    logic          alarm_q;
    logic          alarm_set;

    assign alarm_set = (filt[0] ^ filt[1]) && (mis_cnt_q == AW'(ALARM_CYC - 1));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mis_cnt_q <= '0;
        end else if (!(filt[0] ^ filt[1])) begin
            mis_cnt_q <= '0;
        end else if (mis_cnt_q != AW'(ALARM_CYC)) begin
            mis_cnt_q <= mis_cnt_q + AW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= alarm_set | (alarm_q & ~alarm_clear);
        end
    end

    // ------------------------------------------------------------
    // commands and utilities
    // ------------------------------------------------------------
    dcto_pkg::dcto_cmd_e cmd;
    logic                cmd_off;
    logic                util_req;

    assign cmd      = dcto_pkg::dcto_decode(link.controlword_strobe, link.controlword);
    assign cmd_off  = (cmd == dcto_pkg::CMD_SHUTDOWN) || (cmd == dcto_pkg::CMD_DISABLE);
    assign util_req = utility_mode && (utility_id != dcto_pkg::UTIL_NONE);

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    dcto_pkg::dcto_state_e state_q;
    dcto_pkg::dcto_state_e state_d;
    logic                  pending_q;
    logic                  util_lock_q;
    logic                  util_run_q;
    logic                  pending_set;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dcto_pkg::ST_TORQUE_OFF: begin
                if (!pending_q && !util_req && !util_lock_q
                    && (main_power_on || cmd == dcto_pkg::CMD_SHUTDOWN)) begin
                    state_d = dcto_pkg::ST_IDLE;
                end
            end
            dcto_pkg::ST_IDLE: begin
                if (cmd == dcto_pkg::CMD_SWITCH_ON) begin
                    state_d = dcto_pkg::ST_SWITCHED;
                end else if (cmd == dcto_pkg::CMD_ENABLE_OP || util_req) begin
                    state_d = dcto_pkg::ST_RUN;
                end
            end
            dcto_pkg::ST_SWITCHED: begin
                if (cmd == dcto_pkg::CMD_ENABLE_OP) begin
                    state_d = dcto_pkg::ST_RUN;
                end else if (cmd_off) begin
                    state_d = dcto_pkg::ST_IDLE;
                end
            end
            dcto_pkg::ST_RUN: begin
                if (cmd_off || (util_run_q && !util_req)) begin
                    state_d = dcto_pkg::ST_IDLE;
                end
            end
        endcase
        if (!both_on) begin
            state_d = dcto_pkg::ST_TORQUE_OFF;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= dcto_pkg::ST_TORQUE_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // enable still held when torque-off struck, or sent during torque-off
    assign pending_set = (state_q == dcto_pkg::ST_RUN && !both_on && !util_run_q)
                      || (state_d == dcto_pkg::ST_TORQUE_OFF && cmd == dcto_pkg::CMD_ENABLE_OP);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_q <= 1'b0;
        end else if (pending_set) begin
            pending_q <= 1'b1;
        end else if (cmd_off) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            util_lock_q <= 1'b0;
        end else if (!both_on && util_req) begin
            util_lock_q <= 1'b1;
        end else if (both_on && !util_req) begin
            util_lock_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            util_run_q <= 1'b0;
        end else if (state_d != dcto_pkg::ST_RUN) begin
            util_run_q <= 1'b0;
        end else if (state_q == dcto_pkg::ST_IDLE && util_req && cmd != dcto_pkg::CMD_ENABLE_OP) begin
            util_run_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic gate_a_q;
    logic gate_b_q;
    logic hwto_q;
    logic idle_q;
    logic ready_q;
    logic open_q;
    logic fmo_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_a_q <= 1'b0;
            gate_b_q <= 1'b0;
        end else begin
            gate_a_q <= (state_d == dcto_pkg::ST_RUN) & filt[0];
            gate_b_q <= (state_d == dcto_pkg::ST_RUN) & filt[1];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hwto_q  <= 1'b1;
            idle_q  <= 1'b0;
            ready_q <= 1'b0;
            open_q  <= 1'b0;
        end else begin
            hwto_q  <= (state_d == dcto_pkg::ST_TORQUE_OFF);
            idle_q  <= (state_d == dcto_pkg::ST_IDLE) || (state_d == dcto_pkg::ST_SWITCHED);
            ready_q <= ((state_d == dcto_pkg::ST_IDLE) || (state_d == dcto_pkg::ST_SWITCHED))
                       && both_on;
            open_q  <= (state_d == dcto_pkg::ST_RUN);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fmo_q <= 1'b0;
        end else begin
            fmo_q <= ~filt[0] & ~filt[1];
        end
    end

    assign gate_drive_a                = gate_a_q;
    assign gate_drive_b                = gate_b_q;
    assign input_timing_alarm          = alarm_q;
    assign link.hardwired_torque_off   = hwto_q;
    assign link.power_stage_idle       = idle_q;
    assign link.servo_ready            = ready_q;
    assign link.operation_enabled      = open_q;
    assign link.failure_monitor_output = fmo_q;

endmodule

/* dcto_host.sv */
`timescale 1ns/10ps
module dcto_host #(
    parameter int unsigned MONITOR_CYC = dcto_pkg::SHUTOFF_CYC
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    dcto_if.host      link,
    input  wire logic request_off_a,
    input  wire logic request_off_b,
    input  wire logic start_request,
    input  wire logic stop_request,
    output logic      motor_enabled,
    output logic      monitor_fault,
    output logic      sequence_busy
);

    localparam int MW = $clog2(MONITOR_CYC + 1);

    // ------------------------------------------------------------
    // safety unit channels
    // ------------------------------------------------------------
    logic sr_a_q;
    logic sr_b_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_a_q <= 1'b0;
            sr_b_q <= 1'b0;
        end else begin
            sr_a_q <= ~request_off_a;
            sr_b_q <= ~request_off_b;
        end
    end

    // ------------------------------------------------------------
    // command sequence
    // ------------------------------------------------------------
    dcto_pkg::dcto_host_e state_q;
    logic [3:0]           cw_q;
    logic                 strobe_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= dcto_pkg::H_IDLE;
            cw_q     <= dcto_pkg::CW_DISABLE;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= 1'b0;
            if (stop_request) begin
                state_q  <= dcto_pkg::H_IDLE;
                cw_q     <= dcto_pkg::CW_SHUTDOWN;
                strobe_q <= 1'b1;
            end else begin
                unique case (state_q)
                    dcto_pkg::H_IDLE: begin
                        if (start_request) begin
                            state_q <= dcto_pkg::H_SHUT;
                        end
                    end
                    dcto_pkg::H_SHUT: begin
                        cw_q     <= dcto_pkg::CW_SHUTDOWN;
                        strobe_q <= 1'b1;
                        state_q  <= dcto_pkg::H_WAIT_BB;
                    end
                    dcto_pkg::H_WAIT_BB: begin
                        if (link.power_stage_idle) begin
                            state_q <= dcto_pkg::H_SWON;
                        end
                    end
                    dcto_pkg::H_SWON: begin
                        cw_q     <= dcto_pkg::CW_SWITCH_ON;
                        strobe_q <= 1'b1;
                        state_q  <= dcto_pkg::H_ENOP;
                    end
                    dcto_pkg::H_ENOP: begin
                        cw_q     <= dcto_pkg::CW_ENABLE_OP;
                        strobe_q <= 1'b1;
                        state_q  <= dcto_pkg::H_RUN;
                    end
                    dcto_pkg::H_RUN: begin
                        if (link.hardwired_torque_off) begin
                            state_q <= dcto_pkg::H_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // failure monitor supervision
    // ------------------------------------------------------------
    logic          expect_on;
    logic [MW-1:0] mis_cnt_q;
    logic          fault_q;
    logic          en_q;
    logic          busy_q;

    assign expect_on = ~sr_a_q & ~sr_b_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mis_cnt_q <= '0;
            fault_q   <= 1'b0;
        end else if (link.failure_monitor_output == expect_on) begin
            mis_cnt_q <= '0;
        end else if (mis_cnt_q == MW'(MONITOR_CYC)) begin
            fault_q   <= 1'b1;
        end else begin
            mis_cnt_q <= mis_cnt_q + MW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_q   <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            en_q   <= link.operation_enabled;
            busy_q <= (state_q != dcto_pkg::H_IDLE) && (state_q != dcto_pkg::H_RUN);
        end
    end

    assign link.safety_request_a   = sr_a_q;
    assign link.safety_request_b   = sr_b_q;
    assign link.controlword        = cw_q;
    assign link.controlword_strobe = strobe_q;
    assign motor_enabled           = en_q;
    assign monitor_fault           = fault_q;
    assign sequence_busy           = busy_q;

endmodule

/* dcto_if.sv */
`timescale 1ns/10ps
interface dcto_if;
    logic       safety_request_a;
    logic       safety_request_b;
    logic [3:0] controlword;
    logic       controlword_strobe;
    logic       hardwired_torque_off;
    logic       power_stage_idle;
    logic       servo_ready;
    logic       operation_enabled;
    logic       failure_monitor_output;

    modport drive (
        input  safety_request_a,
        input  safety_request_b,
        input  controlword,
        input  controlword_strobe,
        output hardwired_torque_off,
        output power_stage_idle,
        output servo_ready,
        output operation_enabled,
        output failure_monitor_output
    );

    modport host (
        output safety_request_a,
        output safety_request_b,
        output controlword,
        output controlword_strobe,
        input  hardwired_torque_off,
        input  power_stage_idle,
        input  servo_ready,
        input  operation_enabled,
        input  failure_monitor_output
    );
endinterface

/* dcto_pkg.sv */
package dcto_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned FILTER_TIME_US  = 500;
    localparam int unsigned SHUTOFF_TIME_MS = 8;
    localparam int unsigned ALARM_TIME_S    = 10;
    // longest off pulse that is still ignored
    localparam int unsigned FILTER_CYC      = CLK_HZ / 1_000_000 * FILTER_TIME_US;
    // longest time from both channels off to motor power cut
    localparam int unsigned SHUTOFF_CYC     = CLK_HZ / 1000 * SHUTOFF_TIME_MS;
    // longest time one channel may differ from the other
    localparam int unsigned ALARM_CYC       = CLK_HZ * ALARM_TIME_S;

    // ------------------------------------------------------------
    // controlword low bits
    // ------------------------------------------------------------
    localparam int          CW_W          = 4;
    localparam int          CW_EN_VOLT    = 1;
    localparam logic [3:0]  CW_SHUTDOWN   = 4'h6;
    localparam logic [3:0]  CW_SWITCH_ON  = 4'h7;
    localparam logic [3:0]  CW_ENABLE_OP  = 4'hF;
    localparam logic [3:0]  CW_DISABLE    = 4'h0;

    typedef enum logic [4:0] {
        CMD_NONE      = 5'h01,
        CMD_SHUTDOWN  = 5'h02,
        CMD_SWITCH_ON = 5'h04,
        CMD_ENABLE_OP = 5'h08,
        CMD_DISABLE   = 5'h10
    } dcto_cmd_e;

    // ------------------------------------------------------------
    // local utilities that energize the motor
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        UTIL_NONE                            = 3'h0,
        UTIL_JOG_UTILITY                     = 3'h1,
        UTIL_ORIGIN_SEARCH_UTILITY           = 3'h2,
        UTIL_PROGRAM_JOG_UTILITY             = 3'h3,
        UTIL_CURRENT_OFFSET_TUNING_UTILITY   = 3'h4,
        UTIL_POLARITY_DETECTION_UTILITY      = 3'h5,
        UTIL_REFERENCE_FREE_AUTOTUNE_UTILITY = 3'h6,
        UTIL_QUICK_FREQUENCY_ANALYSIS_UTILITY = 3'h7
    } dcto_util_e;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TORQUE_OFF = 4'h1,
        ST_IDLE       = 4'h2,
        ST_SWITCHED   = 4'h4,
        ST_RUN        = 4'h8
    } dcto_state_e;

    typedef enum logic [5:0] {
        H_IDLE    = 6'h01,
        H_SHUT    = 6'h02,
        H_WAIT_BB = 6'h04,
        H_SWON    = 6'h08,
        H_ENOP    = 6'h10,
        H_RUN     = 6'h20
    } dcto_host_e;

    // ------------------------------------------------------------
    // controlword decode
    // ------------------------------------------------------------
    function automatic dcto_cmd_e dcto_decode(input logic strobe, input logic [3:0] cw);
        dcto_cmd_e c;
        c = CMD_NONE;
        if (strobe) begin
            if (cw == CW_ENABLE_OP) begin
                c = CMD_ENABLE_OP;
            end else if (cw == CW_SWITCH_ON) begin
                c = CMD_SWITCH_ON;
            end else if (cw == CW_SHUTDOWN) begin
                c = CMD_SHUTDOWN;
            end else if (!cw[CW_EN_VOLT]) begin
                c = CMD_DISABLE;
            end
        end
        return c;
    endfunction

endpackage

/* test_dual_channel_torque_off_control.sv */
`timescale 1ns/10ps
module test_dual_channel_torque_off_control;
    localparam int unsigned FILT = 8;
    localparam int unsigned ALRM = 50;

    logic                 sys_clk;
    logic                 reset_n;
    logic                 request_off_a;
    logic                 request_off_b;
    logic                 start_request;
    logic                 stop_request;
    logic                 main_power_on;
    logic                 utility_mode;
    dcto_pkg::dcto_util_e utility_id;
    logic                 alarm_clear;
    logic                 gate_drive_a;
    logic                 gate_drive_b;
    logic                 input_timing_alarm;
    logic                 motor_enabled;
    logic                 monitor_fault;
    logic                 sequence_busy;
    int                   errors;
    int                   checks_done;
    int                   seed;
    int                   len;
    int                   n;

    dcto_if link_if ();
    dcto_drive #(.FILTER_CYC(FILT), .ALARM_CYC(ALRM)) dcto_drive_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(link_if), .main_power_on(main_power_on), .utility_mode(utility_mode), .utility_id(utility_id),
        .alarm_clear(alarm_clear), .gate_drive_a(gate_drive_a), .gate_drive_b(gate_drive_b),
        .input_timing_alarm(input_timing_alarm));
    dcto_host #(.MONITOR_CYC(20)) dcto_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_if),
        .request_off_a(request_off_a), .request_off_b(request_off_b), .start_request(start_request),
        .stop_request(stop_request), .motor_enabled(motor_enabled), .monitor_fault(monitor_fault),
        .sequence_busy(sequence_busy));
    dcto_checker #(.FILTER_CYC(FILT)) dcto_checker_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .safety_request_a(link_if.safety_request_a), .safety_request_b(link_if.safety_request_b),
        .controlword(link_if.controlword), .controlword_strobe(link_if.controlword_strobe),
        .hardwired_torque_off(link_if.hardwired_torque_off), .power_stage_idle(link_if.power_stage_idle),
        .servo_ready(link_if.servo_ready), .operation_enabled(link_if.operation_enabled),
        .failure_monitor_output(link_if.failure_monitor_output));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic chan(input logic a, input logic b);
        @(posedge sys_clk);
        request_off_a <= a;
        request_off_b <= b;
    endtask

    task automatic cmd(input logic stop);
        @(posedge sys_clk);
        start_request <= !stop;
        stop_request  <= stop;
        @(posedge sys_clk);
        start_request <= 1'b0;
        stop_request  <= 1'b0;
    endtask

    task automatic util(input logic m, input int k);
        @(posedge sys_clk);
        utility_mode <= m;
        utility_id   <= dcto_pkg::dcto_util_e'(3'(k));
    endtask

    task automatic wait_op(input logic want);
        for (int i = 0; i < 300 && link_if.operation_enabled !== want; i++) @(negedge sys_clk);
    endtask

    task automatic test_end(input string name);
        $display("%0s finished, errors %0d", name, errors);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = !sys_clk;
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h0DFF5BC6;
        errors = 0;
        checks_done = 0;
        reset_n = 1'b0;
        {request_off_a, request_off_b, start_request, stop_request, utility_mode, alarm_clear} = 6'h00;
        main_power_on = 1'b1;
        utility_id = dcto_pkg::UTIL_NONE;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        tick(20);
        check(link_if.power_stage_idle, 1'b1);
        check(link_if.servo_ready, 1'b1);
        check(link_if.failure_monitor_output, 1'b0);
        cmd(1'b0);
        wait_op(1'b1);
        check(link_if.operation_enabled, 1'b1);
        check(gate_drive_a & gate_drive_b, 1'b1);
        tick(2);
        check(motor_enabled, 1'b1);
        test_end("recovery");
        for (int i = 0; i < 20; i++) begin
            len = (i == 0) ? FILT : 1 + ($unsigned($random(seed)) % FILT);
            n = $random(seed);
            chan(n[0], !n[0]);
            repeat (len - 1) @(posedge sys_clk);
            chan(1'b0, 1'b0);
            tick(15);
            check(link_if.operation_enabled, 1'b1);
        end
        test_end("glitch");
        chan(1'b1, 1'b0);
        tick(FILT + 8);
        check(link_if.hardwired_torque_off, 1'b1);
        check(gate_drive_a, 1'b0);
        check(link_if.failure_monitor_output, 1'b0);
        check(input_timing_alarm, 1'b0);
        tick(ALRM);
        check(input_timing_alarm, 1'b1);
        chan(1'b0, 1'b0);
        tick(20);
        check(input_timing_alarm, 1'b1);
        check(link_if.hardwired_torque_off, 1'b1);
        @(posedge sys_clk) alarm_clear <= 1'b1;
        @(posedge sys_clk) alarm_clear <= 1'b0;
        tick(2);
        check(input_timing_alarm, 1'b0);
        cmd(1'b1);
        tick(10);
        check(link_if.power_stage_idle, 1'b1);
        cmd(1'b0);
        wait_op(1'b1);
        check(link_if.operation_enabled, 1'b1);
        cmd(1'b1);
        tick(5);
        check(link_if.operation_enabled, 1'b0);
        test_end("single channel");
        chan(1'b1, 1'b1);
        n = 0;
        while (n < 200 && link_if.failure_monitor_output !== 1'b1) begin
            tick(1);
            n++;
        end
        check(n <= FILT + 6, 1'b1);
        check(gate_drive_a | gate_drive_b | link_if.servo_ready, 1'b0);
        chan(1'b0, 1'b0);
        cmd(1'b1);
        tick(10);
        check(link_if.servo_ready, 1'b1);
        chan(1'b1, 1'b1);
        tick(FILT + 8);
        chan(1'b0, 1'b0);
        tick(20);
        check(link_if.power_stage_idle, 1'b1);
        chan(1'b1, 1'b1);
        repeat (FILT - 1) @(posedge sys_clk);
        cmd(1'b0);
        tick(10);
        chan(1'b0, 1'b0);
        tick(20);
        check(link_if.hardwired_torque_off, 1'b1);
        cmd(1'b1);
        tick(10);
        check(link_if.power_stage_idle, 1'b1);
        @(posedge sys_clk) main_power_on <= 1'b0;
        chan(1'b1, 1'b1);
        tick(FILT + 8);
        chan(1'b0, 1'b0);
        tick(20);
        check(link_if.hardwired_torque_off, 1'b1);
        cmd(1'b1);
        tick(10);
        check(link_if.power_stage_idle, 1'b1);
        @(posedge sys_clk) main_power_on <= 1'b1;
        test_end("both channels");
        for (int k = 1; k < 8; k++) begin
            util(1'b1, k);
            tick(5);
            check(link_if.operation_enabled, 1'b1);
            util(1'b0, 0);
            tick(5);
            check(link_if.power_stage_idle, 1'b1);
        end
        util(1'b1, 1);
        tick(5);
        chan(1'b1, 1'b1);
        tick(FILT + 8);
        chan(1'b0, 1'b0);
        tick(20);
        check(link_if.hardwired_torque_off, 1'b1);
        util(1'b0, 0);
        tick(5);
        check(link_if.power_stage_idle, 1'b1);
        util(1'b1, 1);
        tick(5);
        check(link_if.operation_enabled, 1'b1);
        util(1'b0, 0);
        tick(5);
        check(monitor_fault, 1'b0);
        check(sequence_busy, 1'b0);
        test_end("utilities");
        test_done();
    end
endmodule
